// file: ctu_charge_time_unit.sv
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
// Functional notes
// - Any sleep mode forces the current source off.
// - Idle stops the source only when stop_in_idle is set.
// - Reset clears all three registers; module disabled, source off.
// - source_ground_discharge grounds the source output while set.
// - module_enable turns the unit on or off; discharge grounding, range and trim outputs ignore it.
// - delay_generation_enable enables time pulse generation.
// - edge_pass_enable passes edge events; zero blocks them all.
// - With edge_order_enable, edge 2 waits for an edge 1 event.
// - converter_trigger_enable enables the trigger toward the converter.
// - Control high bit 6 always reads zero.
// - second_edge_polarity: one rising, zero falling.
// - second_edge_source: 11 pin a, 10 pin b, 01 compare one, 00 two.
// - first_edge_polarity: one rising, zero falling.
// - first_edge_source uses the same four-way encoding.
// - second_edge_seen reads one after edge 2; software writable.
// - first_edge_seen reads one after edge 1; software writable.
// - current_trim is a six-bit signed offset from nominal.
// - current_range: 11 x100, 10 x10, 01 base, 00 source off.
// - Delay generation with edge 1 set pulses when comparator trips.
module ctu_charge_time_unit (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sleep_mode,
  input  wire logic        idle_mode,
  input  wire logic        edge_input_pin_a,
  input  wire logic        edge_input_pin_b,
  input  wire logic        compare_unit_one,
  input  wire logic        compare_unit_two,
  input  wire logic        comparator_trip,
  output logic             source_drive,
  output logic             source_ground,
  output logic [1:0]       source_range,
  output logic [5:0]       source_trim,
  output logic             converter_trigger,
  output logic             pulse_output_pin
);

  logic [7:0] unit_control_high;
  logic [7:0] unit_control_low;
  logic [7:0] current_source_control;
  logic [7:0] next_unit_control_high;
  logic [7:0] next_unit_control_low;
  logic [7:0] next_current_source_control;
  logic [3:0] src_prev;
  logic       trip_prev;
  ctu_pkg::ctu_wr_e wr_state;
  ctu_pkg::ctu_wr_e next_wr_state;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_drive;
  logic        next_ground;
  logic        next_trigger;
  logic        next_pulse;
  logic        first_evt;
  logic        second_evt;
  logic        source_allowed;
  logic        wr_go;
  logic        rd_go;

  // Select one of four sources and detect its programmed edge
  function automatic logic edge_hit(input logic [1:0] sel, input logic pol,
                                    input logic [3:0] now, input logic [3:0] was);
    logic n;
    logic p;
    n = now[sel];
    p = was[sel];
    edge_hit = pol ? (n & ~p) : (~n & p);
  endfunction

  // Index order matches the source encoding
  logic [3:0] src_now;
  assign src_now = {edge_input_pin_a, edge_input_pin_b, compare_unit_one, compare_unit_two};

  assign source_allowed = unit_control_high[ctu_pkg::HI_MODULE_ENABLE] & ~sleep_mode &
                          ~(idle_mode & unit_control_high[ctu_pkg::HI_STOP_IN_IDLE]);

  always_comb
  begin
    first_evt = unit_control_high[ctu_pkg::HI_MODULE_ENABLE] &
                unit_control_high[ctu_pkg::HI_EDGE_PASS] &
                edge_hit(unit_control_low[ctu_pkg::LO_FIRST_SRC_HI:ctu_pkg::LO_FIRST_SRC_LO],
                         unit_control_low[ctu_pkg::LO_FIRST_POL], src_now, src_prev);
    // with edge order set, edge 2 waits for edge 1
    second_evt = unit_control_high[ctu_pkg::HI_MODULE_ENABLE] &
                 unit_control_high[ctu_pkg::HI_EDGE_PASS] &
                 (~unit_control_high[ctu_pkg::HI_EDGE_ORDER] |
                  unit_control_low[ctu_pkg::LO_FIRST_SEEN]) &
                 edge_hit(unit_control_low[ctu_pkg::LO_SECOND_SRC_HI:ctu_pkg::LO_SECOND_SRC_LO],
                          unit_control_low[ctu_pkg::LO_SECOND_POL], src_now, src_prev);
  end

  assign wr_go = (wr_state == ctu_pkg::CTU_W_IDLE) & s_axi_awvalid & s_axi_wvalid;
  assign rd_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;

  // Register file and write channel
  always_comb
  begin
    next_unit_control_high = unit_control_high;
    next_unit_control_low = unit_control_low;
    next_current_source_control = current_source_control;
    next_wr_state = wr_state;
    next_bresp = s_axi_bresp;
    case (wr_state)
      ctu_pkg::CTU_W_IDLE:
      begin
        if (wr_go)
        begin
          next_wr_state = ctu_pkg::CTU_W_RESP;
          next_bresp = ctu_pkg::RESP_OKAY;
          if (s_axi_wstrb[0])
          begin
            case (s_axi_awaddr)
              ctu_pkg::ADDR_CTRL_HIGH:
                next_unit_control_high = s_axi_wdata[7:0] & ctu_pkg::HI_WRITE_MASK;
              ctu_pkg::ADDR_CTRL_LOW:
                next_unit_control_low = s_axi_wdata[7:0];
              ctu_pkg::ADDR_CURRENT:
                next_current_source_control = s_axi_wdata[7:0];
              ctu_pkg::ADDR_STATUS:
                next_bresp = ctu_pkg::RESP_SLVERR;
              default:
                next_bresp = ctu_pkg::RESP_SLVERR;
            endcase
          end
          else if (s_axi_awaddr > ctu_pkg::ADDR_CURRENT)
          begin
            next_bresp = ctu_pkg::RESP_SLVERR;
          end
        end
      end
      ctu_pkg::CTU_W_RESP:
      begin
        if (s_axi_bvalid & s_axi_bready)
        begin
          next_wr_state = ctu_pkg::CTU_W_IDLE;
        end
      end
      default:
        next_wr_state = ctu_pkg::CTU_W_IDLE;
    endcase
    // hardware set wins over software write
    if (first_evt)
    begin
      next_unit_control_low[ctu_pkg::LO_FIRST_SEEN] = 1'b1;
    end
    if (second_evt)
    begin
      next_unit_control_low[ctu_pkg::LO_SECOND_SEEN] = 1'b1;
    end
  end

  // Read channel and outputs
  always_comb
  begin
    next_arready = 1'b0;
    // Read data is offered only after the address handshake has completed
    next_rvalid = s_axi_arready | (s_axi_rvalid & ~s_axi_rready);
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (rd_go)
    begin
      next_arready = 1'b1;
      next_rresp = ctu_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ctu_pkg::ADDR_CTRL_HIGH: next_rdata = {24'h000000, unit_control_high};
        ctu_pkg::ADDR_CTRL_LOW:  next_rdata = {24'h000000, unit_control_low};
        ctu_pkg::ADDR_CURRENT:   next_rdata = {24'h000000, current_source_control};
        ctu_pkg::ADDR_STATUS:    next_rdata = {31'h00000000, source_allowed};
        default:
        begin
          next_rdata = 32'h00000000;
          next_rresp = ctu_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_drive = source_allowed &
                 (current_source_control[ctu_pkg::CUR_RANGE_HI:ctu_pkg::CUR_RANGE_LO] !=
                  ctu_pkg::RANGE_OFF) &
                 (unit_control_low[ctu_pkg::LO_FIRST_SEEN] ^
                  unit_control_low[ctu_pkg::LO_SECOND_SEEN]);
    next_ground = unit_control_high[ctu_pkg::HI_DISCHARGE];
    next_trigger = unit_control_high[ctu_pkg::HI_CONV_TRIG] & source_allowed & second_evt;
    next_pulse = unit_control_high[ctu_pkg::HI_DELAY_GEN] & source_allowed &
                 unit_control_low[ctu_pkg::LO_FIRST_SEEN] & comparator_trip & ~trip_prev;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unit_control_high <= ctu_pkg::REG_RESET;
      unit_control_low <= ctu_pkg::REG_RESET;
      current_source_control <= ctu_pkg::REG_RESET;
      wr_state <= ctu_pkg::CTU_W_IDLE;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
      src_prev <= 4'h0;
      trip_prev <= 1'b0;
      source_drive <= 1'b0;
      source_ground <= 1'b0;
      source_range <= 2'h0;
      source_trim <= 6'h00;
      converter_trigger <= 1'b0;
      pulse_output_pin <= 1'b0;
    end
    else
    begin
      unit_control_high <= next_unit_control_high;
      unit_control_low <= next_unit_control_low;
      current_source_control <= next_current_source_control;
      wr_state <= next_wr_state;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      src_prev <= src_now;
      trip_prev <= comparator_trip;
      source_drive <= next_drive;
      source_ground <= next_ground;
      // trim passed through as signed code
      source_range <= current_source_control[ctu_pkg::CUR_RANGE_HI:ctu_pkg::CUR_RANGE_LO];
      source_trim <= current_source_control[ctu_pkg::CUR_TRIM_HI:ctu_pkg::CUR_TRIM_LO];
      converter_trigger <= next_trigger;
      pulse_output_pin <= next_pulse;
    end
  end

  // Write handshake takes address and data in the same edge, so both readies are one state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      // Response waits for the address and data handshakes, then holds until taken
      s_axi_bvalid <= s_axi_awready | (s_axi_bvalid & ~s_axi_bready);
    end
  end

  property p_sleep_off;
    @(posedge aclk) disable iff (!aresetn) sleep_mode |=> !source_drive;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("source on in sleep");

  property p_idle_stop;
    @(posedge aclk) disable iff (!aresetn)
      idle_mode && unit_control_high[ctu_pkg::HI_STOP_IN_IDLE] |=> !source_drive;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("source on in idle");

  property p_reset_clear;
    @(posedge aclk) !aresetn |=> unit_control_high == ctu_pkg::REG_RESET &&
      unit_control_low == ctu_pkg::REG_RESET && current_source_control == ctu_pkg::REG_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

  property p_ground;
    @(posedge aclk) disable iff (!aresetn)
      source_ground == $past(unit_control_high[ctu_pkg::HI_DISCHARGE]);
  endproperty
  a_ground: assert property (p_ground) else $error("ground mismatch");

  property p_disabled;
    @(posedge aclk) disable iff (!aresetn)
      !unit_control_high[ctu_pkg::HI_MODULE_ENABLE] |=> !source_drive && !pulse_output_pin;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled unit active");

  property p_block;
    @(posedge aclk) disable iff (!aresetn)
      !unit_control_high[ctu_pkg::HI_EDGE_PASS] && !unit_control_low[ctu_pkg::LO_FIRST_SEEN]
      && !wr_go |=> !unit_control_low[ctu_pkg::LO_FIRST_SEEN];
  endproperty
  a_block: assert property (p_block) else $error("blocked edge accepted");

  property p_order;
    @(posedge aclk) disable iff (!aresetn)
      unit_control_high[ctu_pkg::HI_EDGE_ORDER] && !unit_control_low[ctu_pkg::LO_FIRST_SEEN]
      && !unit_control_low[ctu_pkg::LO_SECOND_SEEN] && !wr_go
      |=> !unit_control_low[ctu_pkg::LO_SECOND_SEEN];
  endproperty
  a_order: assert property (p_order) else $error("edge order broken");

  property p_bit6;
    @(posedge aclk) disable iff (!aresetn) !unit_control_high[ctu_pkg::HI_UNUSED];
  endproperty
  a_bit6: assert property (p_bit6) else $error("bit 6 set");

  property p_seen_set;
    @(posedge aclk) disable iff (!aresetn)
      first_evt |=> unit_control_low[ctu_pkg::LO_FIRST_SEEN];
  endproperty
  a_seen_set: assert property (p_seen_set) else $error("edge 1 not recorded");

  property p_pulse;
    @(posedge aclk) disable iff (!aresetn)
      pulse_output_pin |-> $past(unit_control_high[ctu_pkg::HI_DELAY_GEN]);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse without delay gen");

  property p_trigger;
    @(posedge aclk) disable iff (!aresetn)
      converter_trigger |-> $past(unit_control_high[ctu_pkg::HI_CONV_TRIG]);
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger while disabled");

  sequence s_trip_rise;
    !comparator_trip ##1 comparator_trip;
  endsequence

  property p_trip_pulse;
    @(posedge aclk) disable iff (!aresetn)
      s_trip_rise ##0 (source_allowed && unit_control_high[ctu_pkg::HI_DELAY_GEN] &&
                       unit_control_low[ctu_pkg::LO_FIRST_SEEN]) |=> pulse_output_pin;
  endproperty
  a_trip_pulse: assert property (p_trip_pulse) else $error("no pulse on trip");

endmodule

// file: ctu_edge_partner.sv
`timescale 1ns/10ps
module ctu_edge_partner (
  input  wire logic aclk,
  output logic      edge_input_pin_a,
  output logic      edge_input_pin_b,
  output logic      compare_unit_one,
  output logic      compare_unit_two,
  output logic      comparator_trip
);
  // Indexed by the source select code, so a test names a line by its code
  logic [3:0] lines;

  assign edge_input_pin_a = lines[3];
  assign edge_input_pin_b = lines[2];
  assign compare_unit_one = lines[1];
  assign compare_unit_two = lines[0];

  initial
  begin
    lines = 4'h0;
    comparator_trip = 1'b0;
  end

  // Park opposite first so exactly one edge of the wanted polarity follows
  task automatic make_edge(input logic [1:0] src, input logic pol);
    @(posedge aclk);
    lines[src] <= ~pol;
    repeat (2) @(posedge aclk);
    lines[src] <= pol;
    repeat (3) @(posedge aclk);
  endtask

  // Capacitor reaching the reference: comparator output rises, then falls
  task automatic trip();
    @(posedge aclk);
    comparator_trip <= 1'b1;
    repeat (2) @(posedge aclk);
    comparator_trip <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
endmodule

// file: ctu_pkg.sv
package ctu_pkg;
  // Register byte addresses
  localparam logic [3:0] ADDR_CTRL_HIGH = 4'h0;
  localparam logic [3:0] ADDR_CTRL_LOW  = 4'h4;
  localparam logic [3:0] ADDR_CURRENT   = 4'h8;
  localparam logic [3:0] ADDR_STATUS    = 4'hc;
  localparam logic [7:0] REG_RESET      = 8'h00;
  // Control high fields
  localparam int HI_MODULE_ENABLE = 7;
  localparam int HI_UNUSED        = 6;
  localparam int HI_STOP_IN_IDLE  = 5;
  localparam int HI_DELAY_GEN     = 4;
  localparam int HI_EDGE_PASS     = 3;
  localparam int HI_EDGE_ORDER    = 2;
  localparam int HI_DISCHARGE     = 1;
  localparam int HI_CONV_TRIG     = 0;
  localparam logic [7:0] HI_WRITE_MASK = 8'hbf;
  // Control low fields
  localparam int LO_SECOND_POL    = 7;
  localparam int LO_SECOND_SRC_HI = 6;
  localparam int LO_SECOND_SRC_LO = 5;
  localparam int LO_FIRST_POL     = 4;
  localparam int LO_FIRST_SRC_HI  = 3;
  localparam int LO_FIRST_SRC_LO  = 2;
  localparam int LO_SECOND_SEEN   = 1;
  localparam int LO_FIRST_SEEN    = 0;
  // Current control fields
  localparam int CUR_TRIM_HI  = 7;
  localparam int CUR_TRIM_LO  = 2;
  localparam int CUR_RANGE_HI = 1;
  localparam int CUR_RANGE_LO = 0;
  // Edge source select encoding
  localparam logic [1:0] SRC_PIN_A   = 2'h3;
  localparam logic [1:0] SRC_PIN_B   = 2'h2;
  localparam logic [1:0] SRC_CMP_ONE = 2'h1;
  localparam logic [1:0] SRC_CMP_TWO = 2'h0;
  localparam logic [1:0] RANGE_OFF   = 2'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CTU_W_IDLE = 2'b01,
    CTU_W_RESP = 2'b10
  } ctu_wr_e;
endpackage

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam logic [3:0] AH = ctu_pkg::ADDR_CTRL_HIGH;
  localparam logic [3:0] AL = ctu_pkg::ADDR_CTRL_LOW;
  localparam logic [3:0] AC = ctu_pkg::ADDR_CURRENT;
  localparam logic [1:0] OK = ctu_pkg::RESP_OKAY;
  logic        aclk, aresetn;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, source_range;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        sleep_mode, idle_mode, comparator_trip;
  logic        edge_input_pin_a, edge_input_pin_b, compare_unit_one, compare_unit_two;
  logic        source_drive, source_ground, converter_trigger, pulse_output_pin;
  logic [5:0]  source_trim;
  int          fails, samples_checked, trig_hits, pulse_hits;

  ctu_charge_time_unit dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_mode, .idle_mode,
    .edge_input_pin_a, .edge_input_pin_b, .compare_unit_one, .compare_unit_two,
    .comparator_trip, .source_drive, .source_ground, .source_range, .source_trim,
    .converter_trigger, .pulse_output_pin
  );

  ctu_edge_partner src (
    .aclk, .edge_input_pin_a, .edge_input_pin_b, .compare_unit_one,
    .compare_unit_two, .comparator_trip
  );

  always #50 aclk = ~aclk;

  // Pulses last one cycle, so they are counted at every edge
  always @(posedge aclk)
  begin
    if (converter_trigger === 1'b1) trig_hits <= trig_hits + 1;
    if (pulse_output_pin === 1'b1) pulse_hits <= pulse_hits + 1;
  end

  task automatic final_report();
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) check(32'h0, 32'h1);
    if (n == 40) final_report();
    check(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 40) check(32'h0, 32'h1);
    if (n == 40) final_report();
    d = s_axi_rdata;
    check(32'(s_axi_rresp), 32'(OK));
  endtask

  task automatic settle_check(input logic seen_now, input logic exp);
    check(32'(seen_now), 32'(exp));
  endtask

  task automatic t_reset();
    logic [31:0] r;
    rd(AH, r); check(r, 32'h0);
    rd(AL, r); check(r, 32'h0);
    rd(AC, r); check(r, 32'h0);
    wr(AH, 8'hff, OK);
    rd(AH, r); check(r, 32'hbf);
    wr(ctu_pkg::ADDR_STATUS, 8'hff, ctu_pkg::RESP_SLVERR);
    wr(AH, 8'h00, OK);
  endtask

  task automatic t_edges();
    logic [31:0] r;
    logic [1:0]  o;
    int          e, s, p, t0;
    wr(AH, 8'h89, OK);
    for (e = 0; e < 2; e++)
      for (s = 0; s < 4; s++)
        for (p = 0; p < 2; p++)
        begin
          // The idle channel watches another line, which stays still
          o = s[1:0] ^ 2'h1;
          t0 = trig_hits;
          wr(AL, e ? {p[0], s[1:0], 1'b0, o, 2'h0} : {1'b0, o, p[0], s[1:0], 2'h0}, OK);
          src.make_edge(s[1:0], p[0]);
          rd(AL, r);
          check(32'(r[e]), 32'h1);
          check(32'(trig_hits - t0), 32'(e));
        end
    wr(AH, 8'h80, OK);
    wr(AL, 8'h1c, OK);
    src.make_edge(2'h3, 1'b1);
    rd(AL, r); check(r, 32'h1c);
    wr(AH, 8'h08, OK);
    src.make_edge(2'h3, 1'b1);
    rd(AL, r); check(r, 32'h1c);
    wr(AH, 8'h8c, OK);
    wr(AL, 8'hcc, OK);
    src.make_edge(2'h2, 1'b1);
    rd(AL, r); check(r, 32'hcc);
    src.make_edge(2'h3, 1'b1);
    src.make_edge(2'h2, 1'b1);
    rd(AL, r); check(r, 32'hcf);
  endtask

  task automatic t_source();
    logic [31:0] r;
    wr(AC, 8'h7d, OK); check(32'({source_trim, source_range}), 32'h7d);
    wr(AC, 8'h85, OK); check(32'({source_trim, source_range}), 32'h85);
    wr(AH, 8'h80, OK);
    wr(AL, 8'h01, OK);
    repeat (3) @(posedge aclk); settle_check(source_drive, 1'b1);
    rd(ctu_pkg::ADDR_STATUS, r); check(r, 32'h1);
    sleep_mode <= 1'b1;
    repeat (3) @(posedge aclk); settle_check(source_drive, 1'b0);
    rd(ctu_pkg::ADDR_STATUS, r); check(r, 32'h0);
    sleep_mode <= 1'b0;
    idle_mode <= 1'b1;
    repeat (3) @(posedge aclk); settle_check(source_drive, 1'b1);
    wr(AH, 8'ha0, OK);
    repeat (3) @(posedge aclk); settle_check(source_drive, 1'b0);
    idle_mode <= 1'b0;
    wr(AH, 8'h80, OK);
    wr(AC, 8'h84, OK);
    repeat (3) @(posedge aclk); settle_check(source_drive, 1'b0);
    wr(AC, 8'h85, OK);
    wr(AL, 8'h03, OK);
    repeat (3) @(posedge aclk); settle_check(source_drive, 1'b0);
    wr(AH, 8'h02, OK);
    repeat (3) @(posedge aclk); settle_check(source_ground, 1'b1);
    wr(AH, 8'h00, OK);
    repeat (3) @(posedge aclk); settle_check(source_ground, 1'b0);
    wr(AH, 8'h80, OK);
    wr(AL, 8'h01, OK);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk); settle_check(source_drive, 1'b0);
    rd(AH, r); check(r, 32'h0);
    rd(AL, r); check(r, 32'h0);
    rd(AC, r); check(r, 32'h0);
  endtask

  task automatic t_pulse();
    int t0;
    wr(AC, 8'h01, OK);
    wr(AH, 8'h90, OK);
    wr(AL, 8'h01, OK);
    t0 = pulse_hits;
    src.trip();
    check(32'(pulse_hits - t0), 32'h1);
    wr(AH, 8'h80, OK);
    t0 = pulse_hits;
    src.trip();
    check(32'(pulse_hits - t0), 32'h0);
  endtask

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {sleep_mode, idle_mode} = '0;
    {fails, samples_checked, trig_hits, pulse_hits} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_edges();
    t_source();
    t_pulse();
    final_report();
  end
endmodule
